// file: core/pfs_core.sv
// Program counter, status word, accumulator pair and circular return stack of the CPU.
// Assumes the sequencer issues one operation per cycle on op and holds it for one cycle;
// calls and interrupt entries take two cycles, during which op must be none.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "pfs_defines.svh"
// How it works
// - Carry or borrow out of low accumulator moves into the high accumulator.
// - Writing zero to status bit 6 clears auxiliary carry.
// - Program counter is 13 bits: 11 counting bits, 2 latched bank bits.
// - Jump and call load the upper latches from status bits 3 and 4.
// - Bank bits change only by bank select, status word write or either return.
// - Counting past a 2k bank end wraps within the same bank.
// - Conditional jump replaces only the low byte, staying in its page.
// - Interrupt entry leaves bank bits unchanged.
// - Status bits 0-2 mirror the stack index, 3-4 bank, 5 register bank.
// - Bit 6 captures carry from bit 3 into bit 4 on an add.
// - Bit 7 is the carry out of the 8-bit accumulator.
// - Calls and interrupts push status bits 3-7 with the program counter.
// - Plain return restores bank bits only; restoring return restores all five.
// - User flag zero is never stacked and keeps its value.
// - Reset clears status bits 0 to 5.
// - Stack index is a 3-bit up/down counter over RAM 8 to 23.
// - Each entry is two bytes; index zero addresses locations 8 and 9.
// - Index wraps 111 to 000 on push and 000 to 111 on pop silently.
// - Odd stack bytes carry two extra bits for the bank bits.
module pfs_core
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire pfs_pkg::pfs_op_e op,
    input wire logic [12:0] target,
    input wire logic [1:0] bank_sel,
    input wire logic [7:0] sw_wdata,
    input wire logic [7:0] alu_a,
    input wire logic [7:0] alu_b,
    input wire logic alu_sub,
    input wire logic flag_zero_wr,
    input wire logic flag_zero_val,
    output logic [12:0] pc,
    output logic [7:0] program_status_word,
    output logic [7:0] accumulator,
    output logic [7:0] upper_accumulator,
    output logic user_flag_zero,
    output logic busy
);
    pfs_pkg::pfs_state_e state;
    logic [2:0] stack_index;
    logic [1:0] bank_ff;
    logic reg_bank;
    logic aux_carry;
    logic carry;
    logic [12:0] return_pc;
    logic [4:0] saved_bits;
    logic entry_call;
    logic stk_wr;
    logic [3:0] stk_wr_index;
    logic [9:0] stk_wr_data;
    logic [3:0] stk_rd_index;
    logic [9:0] stk_rd_data;
    logic [2:0] pop_index;
    logic is_return;
    logic [8:0] low_sum;
    logic [4:0] nib_sum;
    // =====================================================
    // Helpers
    function automatic logic [12:0] next_in_bank(input logic [12:0] cur);
        logic [10:0] low;
        low = cur[10:0] + 11'h001;
        return {cur[12:11], low};
    endfunction
    function automatic logic [3:0] entry_byte(input logic [2:0] idx, input logic odd);
        return {idx, odd};
    endfunction
    // =====================================================
    // Sequencing state
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state <= pfs_pkg::PFS_ST_IDLE;
        end
        else if (state == pfs_pkg::PFS_ST_IDLE &&
                 (op == pfs_pkg::PFS_OP_CALL || op == pfs_pkg::PFS_OP_INT_ENTRY))
        begin
            state <= pfs_pkg::PFS_ST_SECOND;
        end
        else
        begin
            state <= pfs_pkg::PFS_ST_IDLE;
        end
    end
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            busy <= 1'b0;
        end
        else
        begin
            busy <= state == pfs_pkg::PFS_ST_IDLE &&
                    (op == pfs_pkg::PFS_OP_CALL || op == pfs_pkg::PFS_OP_INT_ENTRY);
        end
    end
    // =====================================================
    // Push capture: the return address and status bits are frozen at entry,
    // so the second byte written matches the first.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            return_pc <= `PFS_PC_RESET;
            saved_bits <= 5'h00;
            entry_call <= 1'b0;
        end
        else if (state == pfs_pkg::PFS_ST_IDLE &&
                 (op == pfs_pkg::PFS_OP_CALL || op == pfs_pkg::PFS_OP_INT_ENTRY))
        begin
            return_pc <= next_in_bank(pc);
            saved_bits <= program_status_word[7:3];
            entry_call <= op == pfs_pkg::PFS_OP_CALL;
        end
    end
    // Stack writes: even byte first, odd byte in the second cycle.
    always_comb
    begin
        stk_wr = 1'b0;
        stk_wr_index = entry_byte(stack_index, 1'b0);
        stk_wr_data = 10'h000;
        if (state == pfs_pkg::PFS_ST_IDLE &&
            (op == pfs_pkg::PFS_OP_CALL || op == pfs_pkg::PFS_OP_INT_ENTRY))
        begin
            stk_wr = 1'b1;
            stk_wr_data = {2'b00, 8'(next_in_bank(pc))};
        end
        else if (state == pfs_pkg::PFS_ST_SECOND)
        begin
            stk_wr = 1'b1;
            stk_wr_index = entry_byte(stack_index, 1'b1);
            stk_wr_data = {return_pc[12:11], saved_bits[4:2], return_pc[10:8],
                           saved_bits[1:0]};
        end
    end
    assign pop_index = stack_index - 3'h1;
    assign stk_rd_index = entry_byte(pop_index, 1'b1);
    pfs_stack_ram u_stack
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(stk_wr),
        .wr_index(stk_wr_index),
        .wr_data(stk_wr_data),
        .rd_index(stk_rd_index),
        .rd_data(stk_rd_data)
    );
    // Even byte of the popped entry is read from a second copy of the store, written alongside the first.
    logic [9:0] even_byte;
    pfs_stack_ram u_stack_even
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(stk_wr),
        .wr_index(stk_wr_index),
        .wr_data(stk_wr_data),
        .rd_index(entry_byte(pop_index, 1'b0)),
        .rd_data(even_byte)
    );
    assign is_return = op == pfs_pkg::PFS_OP_PLAIN_RETURN ||
                       op == pfs_pkg::PFS_OP_RETURN_RESTORING;
    // =====================================================
    // Stack index
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            stack_index <= 3'h0;
        end
        else if (state == pfs_pkg::PFS_ST_SECOND)
        begin
            stack_index <= stack_index + 3'h1;
        end
        else if (state == pfs_pkg::PFS_ST_IDLE && is_return)
        begin
            stack_index <= pop_index;
        end
        else if (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_SW_WRITE)
        begin
            stack_index <= sw_wdata[2:0];
        end
    end
    // =====================================================
    // Program counter
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pc <= `PFS_PC_RESET;
        end
        else if (state == pfs_pkg::PFS_ST_SECOND)
        begin
            pc <= {entry_call ? bank_ff : target[12:11], target[10:0]};
        end
        else if (state == pfs_pkg::PFS_ST_IDLE)
        begin
            unique case (op)
                pfs_pkg::PFS_OP_STEP: pc <= next_in_bank(pc);
                pfs_pkg::PFS_OP_JUMP: pc <= {bank_ff, target[10:0]};
                pfs_pkg::PFS_OP_CALL: pc <= pc;
                // Interrupt vector takes its bank bits from target, not the latches, which stay unchanged.
                pfs_pkg::PFS_OP_INT_ENTRY: pc <= pc;
                pfs_pkg::PFS_OP_COND_JUMP: pc <= {pc[12:8], target[7:0]};
                pfs_pkg::PFS_OP_PLAIN_RETURN,
                pfs_pkg::PFS_OP_RETURN_RESTORING:
                    pc <= {stk_rd_data[9:8], stk_rd_data[4:2], even_byte[7:0]};
                default: pc <= pc;
            endcase
        end
    end
    // =====================================================
    // Bank bits, register bank and flags of the status word
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            bank_ff <= 2'b00;
            reg_bank <= 1'b0;
        end
        else if (state == pfs_pkg::PFS_ST_IDLE)
        begin
            if (op == pfs_pkg::PFS_OP_SEL_BANK)
            begin
                bank_ff <= bank_sel;
            end
            else if (op == pfs_pkg::PFS_OP_SW_WRITE)
            begin
                bank_ff <= sw_wdata[`PFS_SW_MB1:`PFS_SW_MB0];
                reg_bank <= sw_wdata[`PFS_SW_RB];
            end
            else if (is_return)
            begin
                bank_ff <= stk_rd_data[1:0];
                if (op == pfs_pkg::PFS_OP_RETURN_RESTORING)
                begin
                    reg_bank <= stk_rd_data[5];
                end
            end
        end
    end
    assign low_sum = alu_sub ? {1'b0, alu_a} - {1'b0, alu_b} : {1'b0, alu_a} + {1'b0, alu_b};
    assign nib_sum = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            aux_carry <= 1'b0;
            carry <= 1'b0;
            accumulator <= 8'h00;
            upper_accumulator <= 8'h00;
        end
        else if (state == pfs_pkg::PFS_ST_IDLE)
        begin
            if (op == pfs_pkg::PFS_OP_SW_WRITE)
            begin
                aux_carry <= sw_wdata[`PFS_SW_AC];
                carry <= sw_wdata[`PFS_SW_CY];
            end
            else if (op == pfs_pkg::PFS_OP_RETURN_RESTORING)
            begin
                aux_carry <= stk_rd_data[6];
                carry <= stk_rd_data[7];
            end
            else if (op == pfs_pkg::PFS_OP_ALU)
            begin
                accumulator <= low_sum[7:0];
                carry <= low_sum[8];
                if (!alu_sub)
                begin
                    aux_carry <= nib_sum[4];
                end
                if (low_sum[8])
                begin
                    upper_accumulator <= alu_sub ? upper_accumulator - 8'h01
                                                 : upper_accumulator + 8'h01;
                end
            end
        end
    end
    // User flag zero sits outside the stack path entirely.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            user_flag_zero <= 1'b0;
        end
        else if (flag_zero_wr)
        begin
            user_flag_zero <= flag_zero_val;
        end
    end
    assign program_status_word = {carry, aux_carry, reg_bank, bank_ff, stack_index};
    // =====================================================
    // Checks
    property p_jump_latch;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_JUMP)
            |=> pc[12:11] == $past(bank_ff);
    endproperty
    a_jump_latch: assert property (p_jump_latch) else $error("jump latch wrong");
    property p_wrap;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_STEP && pc[10:0] == 11'h7ff)
            |=> pc == {$past(pc[12:11]), 11'h000};
    endproperty
    a_wrap: assert property (p_wrap) else $error("bank wrap wrong");
    property p_page;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_COND_JUMP)
            |=> pc[12:8] == $past(pc[12:8]);
    endproperty
    a_page: assert property (p_page) else $error("page left");
    property p_sel_only;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_SEL_BANK)
            |=> bank_ff == $past(bank_sel) && pc[12:11] == $past(pc[12:11]);
    endproperty
    a_sel_only: assert property (p_sel_only) else $error("bank select wrong");
    property p_int_bank;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_INT_ENTRY)
            |=> $stable(bank_ff) ##1 $stable(bank_ff);
    endproperty
    a_int_bank: assert property (p_int_bank) else $error("interrupt moved bank");
    property p_push_inc;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_CALL)
            |-> ##2 stack_index == $past(stack_index, 2) + 3'h1;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("push index wrong");
    property p_pop_dec;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && is_return)
            |=> stack_index == $past(stack_index) - 3'h1;
    endproperty
    a_pop_dec: assert property (p_pop_dec) else $error("pop index wrong");
    property p_plain_ret;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_PLAIN_RETURN)
            |=> program_status_word[7:5] == $past(program_status_word[7:5]);
    endproperty
    a_plain_ret: assert property (p_plain_ret) else $error("plain return flags");
    property p_mirror;
        @(posedge sys_clk) disable iff (reset)
        (op == pfs_pkg::PFS_OP_SW_WRITE && !busy) |=> program_status_word == $past(sw_wdata);
    endproperty
    a_mirror: assert property (p_mirror) else $error("index mirror");
    property p_upper;
        @(posedge sys_clk) disable iff (reset)
        (state == pfs_pkg::PFS_ST_IDLE && op == pfs_pkg::PFS_OP_ALU && !alu_sub && low_sum[8])
            |=> upper_accumulator == $past(upper_accumulator) + 8'h01;
    endproperty
    a_upper: assert property (p_upper) else $error("upper carry");
    c_call: cover property (@(posedge sys_clk) disable iff (reset)
        op == pfs_pkg::PFS_OP_CALL ##2 op == pfs_pkg::PFS_OP_PLAIN_RETURN);
    c_int: cover property (@(posedge sys_clk) disable iff (reset)
        op == pfs_pkg::PFS_OP_INT_ENTRY ##2 op == pfs_pkg::PFS_OP_RETURN_RESTORING);
    c_wrap_idx: cover property (@(posedge sys_clk) disable iff (reset)
        stack_index == 3'h7 ##1 stack_index == 3'h0);
endmodule

// file: core/pfs_defines.svh
// Constants of the program flow state block: status word fields, reset values, stack layout.
// Assumes inclusion by bare name from design files.
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
// =====================================================
// Status word field positions
`define PFS_SW_SP_LSB 0
`define PFS_SW_MB0 3
`define PFS_SW_MB1 4
`define PFS_SW_RB 5
`define PFS_SW_AC 6
`define PFS_SW_CY 7
// =====================================================
// Reset values
`define PFS_SW_RESET 8'h00
`define PFS_PC_RESET 13'h0000
// =====================================================
// Stack area
`define PFS_STACK_BASE 6'h08
`define PFS_STACK_DEPTH 8
`define PFS_PC_LOW_BITS 11
`endif

// file: core/pfs_pkg.sv
// Types of the program flow state block.
// Assumes nothing of its surroundings.
package pfs_pkg;
    typedef enum logic [3:0]
    {
        PFS_OP_NONE = 4'h0,
        PFS_OP_STEP = 4'h1,
        PFS_OP_JUMP = 4'h2,
        PFS_OP_CALL = 4'h3,
        PFS_OP_COND_JUMP = 4'h4,
        PFS_OP_SEL_BANK = 4'h5,
        PFS_OP_INT_ENTRY = 4'h6,
        PFS_OP_PLAIN_RETURN = 4'h7,
        PFS_OP_RETURN_RESTORING = 4'h8,
        PFS_OP_SW_WRITE = 4'h9,
        PFS_OP_ALU = 4'ha
    } pfs_op_e;
    typedef enum logic [1:0]
    {
        PFS_ST_IDLE = 2'b00,
        PFS_ST_SECOND = 2'b01
    } pfs_state_e;
endpackage

// file: core/pfs_stack_ram.sv
// Holds the sixteen stack bytes; odd bytes carry two extra bits.
// Assumes the caller gives one write per cycle and reads combinationally.
`timescale 1ns/1ps
`include "pfs_defines.svh"
module pfs_stack_ram
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [3:0] wr_index,
    input wire logic [9:0] wr_data,
    input wire logic [3:0] rd_index,
    output logic [9:0] rd_data
);
    logic [9:0] mem [0:2*`PFS_STACK_DEPTH-1];
    // =====================================================
    // Storage
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 2*`PFS_STACK_DEPTH; i++)
            begin
                mem[i] <= 10'h000;
            end
        end
        else if (wr_en)
        begin
            // Even bytes are plain eight bits wide, so the extra bits stay zero there.
            mem[wr_index] <= wr_index[0] ? wr_data : {2'b00, wr_data[7:0]};
        end
    end
    assign rd_data = mem[rd_index];
endmodule

// file: verif/tb_pfs_core.sv
// Self-checking bench for the program flow state core.
// Assumes the core takes one op per edge and stretches calls and interrupt entries over two.
`timescale 1ns/1ps
`include "pfs_defines.svh"
`define CHK(name, exp, got) \
    begin \
        compares++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
        end \
    end
module tb_pfs_core;
    // =====================================================
    // Stimulus and design
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    pfs_pkg::pfs_op_e op = pfs_pkg::PFS_OP_NONE;
    logic [12:0] target = 13'h0000;
    logic [1:0] bank_sel = 2'h0;
    logic [7:0] sw_wdata = 8'h00;
    logic [7:0] alu_a = 8'h00;
    logic [7:0] alu_b = 8'h00;
    logic alu_sub = 1'b0;
    logic flag_zero_wr = 1'b0;
    logic flag_zero_val = 1'b0;
    logic [12:0] pc;
    logic [7:0] program_status_word;
    logic [7:0] accumulator;
    logic [7:0] upper_accumulator;
    logic user_flag_zero;
    logic busy;
    int err_total = 0;
    int compares = 0;
    always #12.5 sys_clk = ~sys_clk;
    pfs_core i_pfs_core
    (
        .sys_clk(sys_clk),
        .reset(reset),
        .op(op),
        .target(target),
        .bank_sel(bank_sel),
        .sw_wdata(sw_wdata),
        .alu_a(alu_a),
        .alu_b(alu_b),
        .alu_sub(alu_sub),
        .flag_zero_wr(flag_zero_wr),
        .flag_zero_val(flag_zero_val),
        .pc(pc),
        .program_status_word(program_status_word),
        .accumulator(accumulator),
        .upper_accumulator(upper_accumulator),
        .user_flag_zero(user_flag_zero),
        .busy(busy)
    );
    // =====================================================
    // Shared tasks
    task automatic summarize();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One op, then a spare cycle; outputs are read 1 ns after the edge so they have settled.
    task automatic do_op(input pfs_pkg::pfs_op_e o, input logic [12:0] t, input logic [7:0] d,
        input logic [7:0] b, input logic s);
        int n;
        @(posedge sys_clk);
        op <= o;
        target <= t;
        sw_wdata <= d;
        bank_sel <= d[1:0];
        alu_a <= d;
        alu_b <= b;
        alu_sub <= s;
        @(posedge sys_clk);
        op <= pfs_pkg::PFS_OP_NONE;
        #1;
        n = 0;
        while (busy === 1'b1 && n < 4)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (busy !== 1'b0)
        begin
            err_total++;
            $display("CHECK FAILED busy expected 0 seen %b", busy);
            summarize();
        end
    endtask
    task automatic set_flag(input logic v);
        @(posedge sys_clk);
        flag_zero_wr <= 1'b1;
        flag_zero_val <= v;
        @(posedge sys_clk);
        flag_zero_wr <= 1'b0;
        #1;
    endtask
    // =====================================================
    // Scenarios
    task automatic t_reset();
        `CHK("pc", 13'h0000, pc)
        `CHK("psw", 8'h00, program_status_word)
        `CHK("acc", 8'h00, accumulator)
        `CHK("uacc", 8'h00, upper_accumulator)
        `CHK("busy", 1'b0, busy)
        $display("TEST reset done");
    endtask
    task automatic t_bank();
        do_op(pfs_pkg::PFS_OP_SEL_BANK, 13'h0000, 8'h02, 8'h00, 1'b0);
        `CHK("psw", 8'h10, program_status_word)
        `CHK("pc", 13'h0000, pc)
        do_op(pfs_pkg::PFS_OP_JUMP, 13'h1fff, 8'h00, 8'h00, 1'b0);
        `CHK("pc", 13'h17ff, pc)
        do_op(pfs_pkg::PFS_OP_STEP, 13'h0000, 8'h00, 8'h00, 1'b0);
        `CHK("pc", 13'h1000, pc)
        do_op(pfs_pkg::PFS_OP_SEL_BANK, 13'h0000, 8'h01, 8'h00, 1'b0);
        `CHK("pc", 13'h1000, pc)
        do_op(pfs_pkg::PFS_OP_STEP, 13'h0000, 8'h00, 8'h00, 1'b0);
        do_op(pfs_pkg::PFS_OP_COND_JUMP, 13'h0af5, 8'h00, 8'h00, 1'b0);
        `CHK("pc", 13'h10f5, pc)
        `CHK("bank", 2'h1, program_status_word[4:3])
        $display("TEST bank done");
    endtask
    task automatic t_alu();
        do_op(pfs_pkg::PFS_OP_ALU, 13'h0000, 8'hf8, 8'h08, 1'b0);
        `CHK("acc", 8'h00, accumulator)
        `CHK("cy_ac", 2'h3, program_status_word[7:6])
        `CHK("uacc", 8'h01, upper_accumulator)
        do_op(pfs_pkg::PFS_OP_ALU, 13'h0000, 8'h00, 8'h01, 1'b1);
        `CHK("acc", 8'hff, accumulator)
        `CHK("cy", 1'b1, program_status_word[7])
        `CHK("uacc", 8'h00, upper_accumulator)
        do_op(pfs_pkg::PFS_OP_ALU, 13'h0000, 8'h12, 8'h34, 1'b0);
        `CHK("acc", 8'h46, accumulator)
        `CHK("cy_ac", 2'h0, program_status_word[7:6])
        do_op(pfs_pkg::PFS_OP_ALU, 13'h0000, 8'h0f, 8'h01, 1'b0);
        `CHK("cy_ac", 2'h1, program_status_word[7:6])
        `CHK("bank", 2'h1, program_status_word[4:3])
        // Bits 0 to 2 are written with the live index so the write cannot move it.
        do_op(pfs_pkg::PFS_OP_SW_WRITE, 13'h0000, 8'h28, 8'h00, 1'b0);
        `CHK("psw", 8'h28, program_status_word)
        `CHK("rb", 1'b1, program_status_word[5])
        $display("TEST alu done");
    endtask
    task automatic t_stack();
        set_flag(1'b1);
        do_op(pfs_pkg::PFS_OP_ALU, 13'h0000, 8'hff, 8'h01, 1'b0);
        `CHK("psw", 8'he8, program_status_word)
        do_op(pfs_pkg::PFS_OP_INT_ENTRY, 13'h0007, 8'h00, 8'h00, 1'b0);
        `CHK("pc", 13'h0007, pc)
        `CHK("psw", 8'he9, program_status_word)
        do_op(pfs_pkg::PFS_OP_SW_WRITE, 13'h0000, 8'h19, 8'h00, 1'b0);
        do_op(pfs_pkg::PFS_OP_RETURN_RESTORING, 13'h0000, 8'h00, 8'h00, 1'b0);
        `CHK("psw", 8'he8, program_status_word)
        `CHK("pc", 13'h10f6, pc)
        `CHK("flag", 1'b1, user_flag_zero)
        do_op(pfs_pkg::PFS_OP_CALL, 13'h0123, 8'h00, 8'h00, 1'b0);
        `CHK("pc", 13'h0923, pc)
        `CHK("psw", 8'he9, program_status_word)
        do_op(pfs_pkg::PFS_OP_SW_WRITE, 13'h0000, 8'h01, 8'h00, 1'b0);
        do_op(pfs_pkg::PFS_OP_PLAIN_RETURN, 13'h0000, 8'h00, 8'h00, 1'b0);
        `CHK("psw", 8'h08, program_status_word)
        `CHK("pc_hi", 2'h2, pc[12:11])
        `CHK("flag", 1'b1, user_flag_zero)
        set_flag(1'b0);
        `CHK("flag", 1'b0, user_flag_zero)
        $display("TEST stack done");
    endtask
    // Nine entries into eight slots: the ninth lands on the oldest one.
    task automatic t_wrap();
        logic [12:0] v;
        for (int k = 0; k < `PFS_STACK_DEPTH + 1; k++)
        begin
            v = 13'h1800 + 13'(k * 8);
            do_op(pfs_pkg::PFS_OP_INT_ENTRY, v, 8'h00, 8'h00, 1'b0);
            `CHK("pc", v, pc)
            `CHK("idx", 3'(k + 1), program_status_word[2:0])
        end
        do_op(pfs_pkg::PFS_OP_RETURN_RESTORING, 13'h0000, 8'h00, 8'h00, 1'b0);
        `CHK("pc", 13'h1839, pc)
        `CHK("psw", 8'h08, program_status_word)
        do_op(pfs_pkg::PFS_OP_RETURN_RESTORING, 13'h0000, 8'h00, 8'h00, 1'b0);
        `CHK("pc", 13'h1831, pc)
        `CHK("psw", 8'h0f, program_status_word)
        $display("TEST wrap done");
    endtask
    task automatic t_reset2();
        do_op(pfs_pkg::PFS_OP_SW_WRITE, 13'h0000, 8'hff, 8'h00, 1'b0);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        `CHK("psw_low", 6'h00, program_status_word[5:0])
        `CHK("pc", 13'h0000, pc)
        $display("TEST reset2 done");
    endtask
    // =====================================================
    // Main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        t_reset();
        t_bank();
        t_alu();
        t_stack();
        t_wrap();
        t_reset2();
        summarize();
    end
endmodule
